//--- inc/vld_map.svh
// Purpose: offsets, fields, reset values and sizes of the line delay
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef VLD_MAP_SVH
`define VLD_MAP_SVH
`define VLD_LANES 8
`define VLD_PIX_W 8
`define VLD_LEN_W 7
`define VLD_PTR_W 10
`define VLD_DEPTH 1024
`define VLD_ADDR_W 12
`define VLD_OFF_CTRL 12'h000
`define VLD_OFF_LEN 12'h004
`define VLD_OFF_STAT 12'h008
`define VLD_CTRL_CASC 0
`define VLD_CTRL_BCAST 1
`define VLD_LEN_RST 7'h01
`define VLD_LEN_ZERO 7'h00
`define VLD_DLY_OFS 10'h008
`define VLD_PTR_ONE 10'h001
`endif

//--- inc/vld_pkg.sv
// Purpose: shared types of the video line delay
// Assumes: vld_map.svh supplies the sizes
// Notes: pixel lanes travel as one packed struct
`default_nettype none
`include "vld_map.svh"
package vld_pkg;
  typedef logic [`VLD_PIX_W-1:0] vld_pix_t;
  typedef struct packed {
    logic [`VLD_LANES-1:0][`VLD_PIX_W-1:0] lane;
  } vld_pix_s;
  typedef struct packed {
    logic bcast;
    logic casc;
  } vld_ctrl_s;
endpackage
`default_nettype wire

//--- hw/vld_top.sv
// Purpose: eight-lane variable length video line delay with APB setup
// Assumes: pixel inputs and blanking pins synchronous to pclk
// Notes: one word shifts in per lane on every pclk edge
`timescale 1ns/10ps
`default_nettype none
`include "vld_map.svh"

// Notes on behaviour
// - eight 8-bit pixel shift lanes, each a separate line delay in plain mode
// - length held until software writes it; a nonzero write loads the new value, a zero write is ignored
// - plain mode: each lane delays four times length plus 8 shifts
// - cascade mode: lanes chained in pairs, delay eight times length plus 16
// - cascade mode: only odd lane outputs, the end of each pair, appear
// - output blanking forces every data output to zero
// - input blanking replaces incoming words by zero before storage
// - broadcast sends input lane 0 into all eight lanes at once, only the four even lanes in cascade mode
module vld_top
  import vld_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`VLD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vld_pix_s pix_in,
  input wire logic in_blank,
  input wire logic out_blank,
  output vld_pix_s pix_out
);

  // delay in shifts for one lane at a given length setting
  function automatic logic [`VLD_PTR_W-1:0] vld_delay(
    input logic [`VLD_LEN_W-1:0] len
  );
    vld_delay = {1'b0, len, 2'b00} + `VLD_DLY_OFS;
  endfunction

  logic [`VLD_LEN_W-1:0] length_r;
  vld_ctrl_s ctrl_r;
  logic [`VLD_PTR_W-1:0] wptr_r;
  logic [`VLD_PTR_W-1:0] raddr;
  logic [`VLD_PTR_W-1:0] dly;
  logic [`VLD_PIX_W-1:0] mem [`VLD_LANES][`VLD_DEPTH];
  vld_pix_s lane_in;
  vld_pix_s rd;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_len;
  logic hit_stat;

  // apb decode; one wait state so every answer comes from a flop
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;
  always_comb begin
    hit_ctrl = 1'b0;
    hit_len = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `VLD_OFF_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `VLD_OFF_LEN) begin
      hit_len = 1'b1;
    end else if (paddr == `VLD_OFF_STAT) begin
      hit_stat = 1'b1;
    end
  end

  // ready pulses for one cycle after the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // unmapped addresses answer with an error, reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~(hit_ctrl | hit_len | hit_stat);
    end
  end

  // read data captured on the same edge that raises ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (hit_ctrl) begin
        prdata <= {30'h0000_0000, ctrl_r.bcast, ctrl_r.casc};
      end else if (hit_len) begin
        prdata <= {25'h000_0000, length_r};
      end else if (hit_stat) begin
        prdata <= {22'h00_0000, wptr_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // length register; loads on the pclk edge while the apb write strobe is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      length_r <= `VLD_LEN_RST;
    end else if (wr_en && hit_len && pwdata[`VLD_LEN_W-1:0] != `VLD_LEN_ZERO) begin
      length_r <= pwdata[`VLD_LEN_W-1:0];
    end
  end

  // mode bits; changing them mid-frame scrambles stored lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r.casc <= pwdata[`VLD_CTRL_CASC];
      ctrl_r.bcast <= pwdata[`VLD_CTRL_BCAST];
    end
  end

  // shared write pointer: all lanes step together every edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= '0;
    end else begin
      wptr_r <= wptr_r + `VLD_PTR_ONE;
    end
  end

  // read tap sits exactly one delay behind the writer
  assign dly = vld_delay(length_r);
  assign raddr = wptr_r - dly;

  // lane input select: blank, broadcast, or chain from the pair partner
  always_comb begin
    lane_in = '0;
    for (int i = 0; i < `VLD_LANES; i++) begin
      rd.lane[i] = mem[i][raddr];
      if (ctrl_r.casc && i[0]) begin
        lane_in.lane[i] = rd.lane[i-1];
      end else if (in_blank) begin
        lane_in.lane[i] = '0;
      end else if (ctrl_r.bcast) begin
        lane_in.lane[i] = pix_in.lane[0];
      end else begin
        lane_in.lane[i] = pix_in.lane[i];
      end
    end
  end

  // ring storage; no reset since stale pixels are flushed in one line
  always_ff @(posedge pclk) begin
    for (int i = 0; i < `VLD_LANES; i++) begin
      mem[i][wptr_r] <= lane_in.lane[i];
    end
  end

  // output flops with blanking and pair masking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_out <= '0;
    end else begin
      for (int i = 0; i < `VLD_LANES; i++) begin
        if (out_blank) begin
          pix_out.lane[i] <= '0;
        end else if (ctrl_r.casc && !i[0]) begin
          pix_out.lane[i] <= '0;
        end else begin
          pix_out.lane[i] <= rd.lane[i];
        end
      end
    end
  end

  // assertion helpers: a tap is trusted only once its slot was written after reset
  logic warm_r;
  logic rd_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 1'b0;
    end else if (&wptr_r) begin
      warm_r <= 1'b1;
    end
  end
  assign rd_ok = warm_r | (wptr_r >= dly);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_len_write;
    wr_en && hit_len && pwdata[`VLD_LEN_W-1:0] != `VLD_LEN_ZERO;
  endsequence

  sequence s_access_start;
    psel && penable && !pready;
  endsequence

  a_len_latch_load: assert property (
    s_len_write |=> length_r == $past(pwdata[`VLD_LEN_W-1:0]))
    else $error("length not loaded on write");

  a_len_zero_kept: assert property (
    (wr_en && hit_len && pwdata[`VLD_LEN_W-1:0] == `VLD_LEN_ZERO) |=> $stable(length_r))
    else $error("zero length was accepted");

  a_len_stable: assert property (
    !(wr_en && hit_len) |=> $stable(length_r))
    else $error("length changed without write");

  a_ptr_advance: assert property (
    presetn |=> wptr_r == $past(wptr_r) + `VLD_PTR_ONE)
    else $error("pointer did not advance");

  a_tap_distance: assert property (
    (wptr_r - raddr) == {1'b0, length_r, 2'b00} + `VLD_DLY_OFS)
    else $error("tap distance wrong");

  a_out_blank_zero: assert property (
    out_blank |=> pix_out == '0)
    else $error("outputs not blanked");

  a_in_blank_zero: assert property (
    (in_blank && !ctrl_r.casc) |-> lane_in == '0)
    else $error("input not blanked");

  a_bcast_all_lanes: assert property (
    (ctrl_r.bcast && !in_blank && !ctrl_r.casc) |-> lane_in.lane[7] == pix_in.lane[0])
    else $error("broadcast missing");

  a_cascade_chain: assert property (
    ctrl_r.casc |-> lane_in.lane[3] == rd.lane[2])
    else $error("pair not chained");

  a_cascade_even_off: assert property (
    (ctrl_r.casc && !out_blank) |=> pix_out.lane[0] == '0)
    else $error("even lane visible in cascade");

  a_apb_one_wait: assert property (
    s_access_start |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  sequence s_ready_pulse;
    pready ##1 !pready;
  endsequence

  a_write_answer: assert property (
    (psel && penable && !pready && pwrite) |=> s_ready_pulse)
    else $error("write not answered after one wait");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  a_rdata_idle_zero: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  a_len_never_zero: assert property (
    length_r != `VLD_LEN_ZERO)
    else $error("length holds zero");

  a_len_read_back: assert property (
    (rd_en && hit_len) |=> prdata == {25'h000_0000, $past(length_r)})
    else $error("length read back wrong");

  a_stat_read_back: assert property (
    (rd_en && hit_stat) |=> prdata == {22'h00_0000, $past(wptr_r)})
    else $error("pointer read back wrong");

  a_ctrl_loaded: assert property (
    (wr_en && hit_ctrl) |=> ctrl_r.casc == $past(pwdata[`VLD_CTRL_CASC])
      && ctrl_r.bcast == $past(pwdata[`VLD_CTRL_BCAST]))
    else $error("control bits not loaded");

  a_plain_own_input: assert property (
    (!ctrl_r.casc && !ctrl_r.bcast && !in_blank) |-> lane_in == pix_in)
    else $error("lane not fed by its own input");

  a_bcast_even_lanes: assert property (
    (ctrl_r.bcast && !in_blank) |-> lane_in.lane[0] == pix_in.lane[0]
      && lane_in.lane[2] == pix_in.lane[0])
    else $error("broadcast not on even lanes");

  a_cascade_even_blank: assert property (
    (ctrl_r.casc && in_blank) |-> lane_in.lane[0] == '0 && lane_in.lane[6] == '0)
    else $error("even lanes not blanked in cascade");

  a_cascade_odd_chain: assert property (
    (rd_ok && ctrl_r.casc) |-> lane_in.lane[7] == rd.lane[6])
    else $error("last pair not chained");

  a_plain_lane_pass: assert property (
    (rd_ok && !ctrl_r.casc && !out_blank) |=> pix_out == $past(rd))
    else $error("tap word not passed to output");

  a_odd_lane_shown: assert property (
    (rd_ok && ctrl_r.casc && !out_blank) |=> pix_out.lane[7] == $past(rd.lane[7]))
    else $error("pair end not shown in cascade");

  a_even_lanes_off: assert property (
    (ctrl_r.casc && !out_blank) |=> pix_out.lane[2] == '0 && pix_out.lane[4] == '0
      && pix_out.lane[6] == '0)
    else $error("even lanes visible in cascade");

endmodule
`default_nettype wire

//--- dv/vld_src.sv
// Purpose: video source feeding the line delay
// Assumes: one word per lane on every pclk edge
// Notes: input blanking raised on about one word in eight
`timescale 1ns/10ps
`default_nettype none
module vld_src
  import vld_pkg::*;
(
  input wire logic pclk,
  output vld_pix_s pix,
  output logic blank
);
  int seed = 32'h40F0B808;
  // quiet until the first edge so no input starts unknown
  initial {pix, blank} = '0;
  // fresh word every edge, like a live raster with no valid strobe
  always @(posedge pclk) begin
    pix <= {$random(seed), $random(seed)};
    blank <= 3'($random(seed)) == 3'h0;
  end
endmodule
`default_nettype wire

//--- dv/tb_vld_top.sv
// Purpose: self-checking bench for the line delay
// Assumes: one wait state apb slave, words noted as the design samples them
// Notes: each note carries the cycle at which its result is due
`timescale 1ns/10ps
`default_nettype none
module tb_vld_top
  import vld_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, out_blank = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd_last = '0;
  logic pready, pslverr, in_blank;
  vld_pix_s pix_in, pix_out;
  int errors = 0, tests_run = 0, cyc = 0;
  int due_q[$];
  vld_pix_s exp_q[$];

  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  vld_top vld_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pix_in(pix_in), .in_blank(in_blank), .out_blank(out_blank),
    .pix_out(pix_out));
  vld_src vld_src_inst (.pclk(pclk), .pix(pix_in), .blank(in_blank));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // the answer is taken only at the edge that sees pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      input logic [31:0] rd, input logic err, input logic [31:0] msk = 32'hFFFF_FFFF);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_last = prdata;
    if (!wr) chk("prdata", 64'(prdata & msk), 64'(rd & msk));
    chk("pslverr", 64'(pslverr), 64'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // what the lanes must show for a word sampled in mode c
  function automatic vld_pix_s exp_of(vld_pix_s w, logic b, logic [1:0] c);
    vld_pix_s s;
    vld_pix_s e;
    for (int i = 0; i < 8; i++) s.lane[i] = b ? 8'h00 : (c[1] ? w.lane[0] : w.lane[i]);
    e = s;
    if (c[0]) begin
      for (int i = 0; i < 8; i += 2) begin
        e.lane[i] = 8'h00;
        e.lane[i + 1] = s.lane[i];
      end
    end
    return e;
  endfunction

  // note 64 words as sampled, then let the last of them come out
  task automatic stream(input logic [1:0] c, input int d);
    repeat (64) begin
      @(posedge pclk);
      due_q.push_back(cyc + d + 1);
      exp_q.push_back(exp_of(pix_in, in_blank, c));
    end
    repeat (d + 4) @(posedge pclk);
  endtask

  // oldest note is compared when its cycle comes round
  always @(posedge pclk) begin
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      chk("pix_out", pix_out, exp_q[0]);
      void'(due_q.pop_front());
      void'(exp_q.pop_front());
    end
  end

  initial begin
    int ct[6] = '{0, 0, 2, 1, 1, 3};
    int ln[6] = '{1, 127, 3, 1, 127, 2};
    int d;
    logic [31:0] stat_a;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
    // two back-to-back status reads sample the pointer four edges apart
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0, 32'hFFFF_FC00);
    stat_a = rd_last;
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0, 32'hFFFF_FC00);
    chk("stat step", 64'(10'(rd_last - stat_a)), 64'h4);
    $display("test registers done");
    for (int t = 0; t < 6; t++) begin
      apb(1'b1, 12'h000, ct[t], 32'h0, 1'b0);
      apb(1'b1, 12'h004, ln[t], 32'h0, 1'b0);
      d = ct[t][0] ? 8 * ln[t] + 16 : 4 * ln[t] + 8;
      stream(2'(ct[t]), d);
      $display("test %0d done, delay %0d", t, d);
    end
    apb(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h2, 1'b0);
    // outputs forced quiet one edge after the blank is driven
    repeat (8) begin
      @(posedge pclk);
      out_blank <= 1'b1;
      due_q.push_back(cyc + 2);
      exp_q.push_back('0);
    end
    @(posedge pclk);
    out_blank <= 1'b0;
    repeat (4) @(posedge pclk);
    $display("test blanking done");
    final_report();
  end

  // watchdog well beyond the roughly 2150 cycles the tests need
  initial begin
    #(40 * 8000);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
